// File: src/lsc_light_sensor.sv
// Serial command port and clock crossings of the light sensor control block.
// Operation
// - Opcode 00 powers down; opcode 01 powers on and waits idle.
// - Result clear opcode works only while powered on, ignored when down.
// - Opcode 10 starts continuous 1 lux-per-count measuring, 120 ms period.
// - Opcode 11 starts continuous half-lux measuring, 120 ms period.
// - Opcode 13 starts continuous 4 lux-per-count measuring, 16 ms period.
// - Opcodes 20, 21, 23 measure once, then power down alone.
// - Prefix 01000 loads time value bits 7..5; prefix 011 loads 4..0.
// - Result is sixteen bits, zero after reset.
// - Integration time value is eight bits, resets to 45 hex.
// - Measurement logic runs on the internal oscillator clock.
// - Reset pin low clears every register behind the pin filters and holds power down.
// - Result clear opcode zeroes only the result register.
// - Continuous modes overwrite the result after every period.
// - Bus address is 5C hex with select high, 23 hex low.
// - Period scales linearly with the integration time value.
`timescale 1ns/10ps
module lsc_light_sensor #(
	parameter int H_CYC = lsc_pkg::MEAS_H_CYC,
	parameter int L_CYC = lsc_pkg::MEAS_L_CYC
) (
	input wire logic core_clk, // Bus-side clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic osc_clk, // Internal oscillator clock.
	input wire logic rst_pin_n, // Reset pin, active low.
	input wire logic scl, // Serial clock pin.
	input wire logic sda_in, // Serial data pin level.
	output logic sda_out, // Serial data drive value.
	output logic sda_oe, // Serial data drive enable.
	input wire logic addr_sel, // Address select pin.
	input wire logic [15:0] conv_count, // Converter count, osc domain.
	output logic pwr_on, // Powered on, osc domain.
	output logic meas_active // Integration running, osc domain.
);

	// ==========================================================
	// Pin filters: three stages, a change counts once two agree.
	logic [3:0] pin_raw;
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_f;
	logic scl_f;
	logic sda_f;
	logic addr_f;
	logic rst_pin_f;

	assign pin_raw = {rst_pin_n, addr_sel, sda_in, scl};
	assign scl_f = pin_f[0];
	assign sda_f = pin_f[1];
	assign addr_f = pin_f[2];
	assign rst_pin_f = pin_f[3];

	always_ff @(posedge core_clk) begin
		pin_s1 <= pin_raw;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pin_f <= lsc_pkg::PIN_F_RESET;
		end else begin
			pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
		end
	end

	logic core_rst_r;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			core_rst_r <= 1'b1;
		end else begin
			core_rst_r <= !rst_pin_f;
		end
	end

	// ==========================================================
	// Bus condition detection
	logic scl_d_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [6:0] my_addr;

	always_ff @(posedge core_clk) begin
		if (core_rst_r) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_f;
			sda_d_r <= sda_f;
		end
	end

	assign scl_rise = scl_f && !scl_d_r;
	assign scl_fall = !scl_f && scl_d_r;
	assign start_c = scl_f && scl_d_r && sda_d_r && !sda_f;
	assign stop_c = scl_f && scl_d_r && !sda_d_r && sda_f;
	assign my_addr = addr_f ? lsc_pkg::ADDR_SEL_HI : lsc_pkg::ADDR_SEL_LO;

	// ==========================================================
	// Crossings between the bus side and the oscillator side
	logic cmd_req_r;
	logic [7:0] cmd_op_r;
	logic ack_s1;
	logic ack_s2;
	logic cmd_busy;
	logic res_s1;
	logic res_s2;
	logic res_s3;
	logic [15:0] res_shadow_r;
	logic osc_rst_m;
	logic osc_rst;
	logic req_s1;
	logic req_s2;
	logic req_s3;
	logic cmd_valid;
	logic [15:0] eng_result;
	logic eng_tgl;

	assign cmd_busy = cmd_req_r != ack_s2;

	// ==========================================================
	// Serial protocol engine
	lsc_pkg::lsc_bus_e st_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [15:0] rd_word_r;
	logic rw_r;
	logic sda_oe_r;
	logic sda_out_r;
	logic byte_hi_r;
	logic m_ack_r;
	logic opc_done_r;
	logic byte_end;
	logic opc_take;

	assign byte_end = scl_fall && (bit_cnt_r == lsc_pkg::BITS_PER_BYTE);
	assign opc_take = (st_r == lsc_pkg::BUS_WDAT_S) && byte_end && !opc_done_r && !cmd_busy;

	always_ff @(posedge core_clk) begin
		if (core_rst_r) begin
			st_r <= lsc_pkg::BUS_IDLE_S;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			rd_word_r <= 16'h0000;
			rw_r <= 1'b0;
			sda_oe_r <= 1'b0;
			byte_hi_r <= 1'b0;
			m_ack_r <= 1'b0;
			opc_done_r <= 1'b0;
		end else if (start_c) begin
			st_r <= lsc_pkg::BUS_ADDR_S;
			bit_cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
			opc_done_r <= 1'b0;
		end else if (stop_c) begin
			st_r <= lsc_pkg::BUS_IDLE_S;
			sda_oe_r <= 1'b0;
		end else begin
			case (st_r)
				lsc_pkg::BUS_ADDR_S, lsc_pkg::BUS_WDAT_S: begin
					if (scl_rise && bit_cnt_r != lsc_pkg::BITS_PER_BYTE) begin
						shift_r <= {shift_r[6:0], sda_f};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_end && st_r == lsc_pkg::BUS_ADDR_S) begin
						if (shift_r[7:1] == my_addr) begin
							st_r <= lsc_pkg::BUS_ACKA_S;
							sda_oe_r <= 1'b1;
							rw_r <= shift_r[0];
							rd_word_r <= res_shadow_r;
						end else begin
							st_r <= lsc_pkg::BUS_IDLE_S;
						end
					end else if (byte_end) begin
						if (opc_take) begin
							st_r <= lsc_pkg::BUS_ACKW_S;
							sda_oe_r <= 1'b1;
							opc_done_r <= 1'b1;
						end else begin
							st_r <= lsc_pkg::BUS_IDLE_S;
						end
					end
				end
				lsc_pkg::BUS_ACKA_S: begin
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (rw_r) begin
							st_r <= lsc_pkg::BUS_RDAT_S;
							tx_r <= rd_word_r[15:8];
							sda_oe_r <= !rd_word_r[15];
							bit_cnt_r <= 4'h1;
							byte_hi_r <= 1'b1;
						end else begin
							st_r <= lsc_pkg::BUS_WDAT_S;
							sda_oe_r <= 1'b0;
						end
					end
				end
				lsc_pkg::BUS_ACKW_S: begin
					if (scl_fall) begin
						// A further byte is shifted in only to be refused.
						st_r <= lsc_pkg::BUS_WDAT_S;
						bit_cnt_r <= 4'h0;
						sda_oe_r <= 1'b0;
					end
				end
				lsc_pkg::BUS_RDAT_S: begin
					if (byte_end) begin
						st_r <= lsc_pkg::BUS_ACKR_S;
						sda_oe_r <= 1'b0;
					end else if (scl_fall) begin
						sda_oe_r <= !tx_r[6];
						tx_r <= {tx_r[6:0], 1'b0};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				end
				lsc_pkg::BUS_ACKR_S: begin
					if (scl_rise) begin
						m_ack_r <= !sda_f;
					end else if (scl_fall) begin
						if (m_ack_r && byte_hi_r) begin
							st_r <= lsc_pkg::BUS_RDAT_S;
							tx_r <= rd_word_r[7:0];
							sda_oe_r <= !rd_word_r[7];
							bit_cnt_r <= 4'h1;
							byte_hi_r <= 1'b0;
						end else begin
							st_r <= lsc_pkg::BUS_IDLE_S;
						end
					end
				end
				default: st_r <= lsc_pkg::BUS_IDLE_S;
			endcase
		end
	end

	// Open drain: the pin only ever pulls low.
	always_ff @(posedge core_clk) begin
		sda_out_r <= 1'b0;
	end

	assign sda_out = sda_out_r;
	assign sda_oe = sda_oe_r;

	// ==========================================================
	// Command launch: the opcode is held until the next toggle, which
	// cannot come before the oscillator side has echoed this one.
	always_ff @(posedge core_clk) begin
		if (core_rst_r) begin
			cmd_req_r <= 1'b0;
			cmd_op_r <= 8'h00;
		end else if (opc_take) begin
			cmd_op_r <= shift_r;
			cmd_req_r <= !cmd_req_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (core_rst_r) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			res_s1 <= 1'b0;
			res_s2 <= 1'b0;
			res_s3 <= 1'b0;
		end else begin
			ack_s1 <= req_s3;
			ack_s2 <= ack_s1;
			res_s1 <= eng_tgl;
			res_s2 <= res_s1;
			res_s3 <= res_s2;
		end
	end

	// The result word is stable for a full oscillator period after its
	// toggle, far longer than the two stages the toggle passes here.
	always_ff @(posedge core_clk) begin
		if (core_rst_r) begin
			res_shadow_r <= lsc_pkg::RESULT_RESET;
		end else if (res_s2 != res_s3) begin
			res_shadow_r <= eng_result;
		end
	end

	// ==========================================================
	// Oscillator side
	always_ff @(posedge osc_clk) begin
		osc_rst_m <= core_rst_r;
		osc_rst <= osc_rst_m;
	end

	always_ff @(posedge osc_clk) begin
		if (osc_rst) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= cmd_req_r;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	assign cmd_valid = req_s2 != req_s3;

	lsc_meas_engine #(
		.H_CYC(H_CYC),
		.L_CYC(L_CYC)
	) u_engine (
		.osc_clk(osc_clk),
		.osc_rst(osc_rst),
		.cmd_valid(cmd_valid),
		.cmd_op(cmd_op_r),
		.conv_count(conv_count),
		.result_r(eng_result),
		.result_tgl_r(eng_tgl),
		.pwr_on_r(pwr_on),
		.meas_active_r(meas_active)
	);

	// ==========================================================
	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst || core_rst_r);

	a_addr_ack: assert property (st_r == lsc_pkg::BUS_ADDR_S && byte_end && !start_c &&
		!stop_c && shift_r[7:1] == my_addr |=> sda_oe_r && st_r == lsc_pkg::BUS_ACKA_S)
		else $error("address not acknowledged");
	a_addr_nack: assert property (st_r == lsc_pkg::BUS_ADDR_S && byte_end && !start_c &&
		!stop_c && shift_r[7:1] != my_addr |=> !sda_oe_r && st_r == lsc_pkg::BUS_IDLE_S)
		else $error("foreign address acknowledged");
	a_read_high_first: assert property (st_r == lsc_pkg::BUS_ACKA_S && scl_fall && rw_r &&
		!start_c && !stop_c |=> tx_r == $past(rd_word_r[15:8]) &&
		sda_oe_r == !$past(rd_word_r[15])) else $error("high byte not first");
	a_cmd_issue: assert property (opc_take && !start_c && !stop_c |=>
		cmd_op_r == $past(shift_r) && cmd_req_r != $past(cmd_req_r) && opc_done_r)
		else $error("opcode not launched");
	a_second_refused: assert property (st_r == lsc_pkg::BUS_WDAT_S && byte_end &&
		opc_done_r && !start_c && !stop_c |=> !sda_oe_r ##1 $stable(cmd_req_r))
		else $error("chained opcode accepted");
	a_pin_reset: assert property (disable iff (srst) !rst_pin_f |=> core_rst_r ##1
		(res_shadow_r == 16'h0000 && st_r == lsc_pkg::BUS_IDLE_S)) else $error("pin reset lost");

endmodule : lsc_light_sensor

// File: src/lsc_pkg.sv
// Shared constants, opcodes and state encodings of the light sensor control block.
package lsc_pkg;

	// ==========================================================
	// Opcodes
	localparam logic [7:0] OP_PWR_DOWN = 8'h00;
	localparam logic [7:0] OP_PWR_ON = 8'h01;
	localparam logic [7:0] OP_RESULT_CLR = 8'h07;
	localparam logic [7:0] OP_CONT_H = 8'h10;
	localparam logic [7:0] OP_CONT_HALF = 8'h11;
	localparam logic [7:0] OP_CONT_L = 8'h13;
	localparam logic [7:0] OP_ONCE_H = 8'h20;
	localparam logic [7:0] OP_ONCE_HALF = 8'h21;
	localparam logic [7:0] OP_ONCE_L = 8'h23;
	localparam logic [4:0] OP_MT_HI_PFX = 5'h08;
	localparam logic [2:0] OP_MT_LO_PFX = 3'h3;
	localparam int OP_CONT_BIT = 4;
	localparam int OP_LRES_BIT = 1;

	// ==========================================================
	// Reset values, addresses and byte framing
	localparam logic [7:0] MT_RESET = 8'h45;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [6:0] ADDR_SEL_HI = 7'h5C;
	localparam logic [6:0] ADDR_SEL_LO = 7'h23;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// The reset pin stage starts asserted, so the bus side leaves reset once the pin reads high.
	localparam logic [3:0] PIN_F_RESET = 4'h3;

	// ==========================================================
	// Timing on the internal oscillator
	localparam int OSC_HZ = 320000;
	localparam int MEAS_H_MS = 120;
	localparam int MEAS_L_MS = 16;
	localparam int MT_DEFAULT = 69;
	localparam int MEAS_H_CYC = MEAS_H_MS * (OSC_HZ / 1000);
	localparam int MEAS_L_CYC = MEAS_L_MS * (OSC_HZ / 1000);

	// ==========================================================
	// State encodings
	typedef enum logic [2:0] {
		PWR_DOWN_S = 3'h1,
		PWR_IDLE_S = 3'h2,
		PWR_MEAS_S = 3'h4
	} lsc_pwr_e;

	typedef enum logic [6:0] {
		BUS_IDLE_S = 7'h01,
		BUS_ADDR_S = 7'h02,
		BUS_ACKA_S = 7'h04,
		BUS_WDAT_S = 7'h08,
		BUS_ACKW_S = 7'h10,
		BUS_RDAT_S = 7'h20,
		BUS_ACKR_S = 7'h40
	} lsc_bus_e;

	function automatic logic is_meas_op(input logic [7:0] op);
		return (op == OP_CONT_H) || (op == OP_CONT_HALF) || (op == OP_CONT_L) ||
			(op == OP_ONCE_H) || (op == OP_ONCE_HALF) || (op == OP_ONCE_L);
	endfunction : is_meas_op

endpackage : lsc_pkg

// File: src/lsc_meas_engine.sv
// Measurement sequencer on the internal oscillator clock.
`timescale 1ns/10ps
module lsc_meas_engine #(
	parameter int H_CYC = lsc_pkg::MEAS_H_CYC,
	parameter int L_CYC = lsc_pkg::MEAS_L_CYC
) (
	input wire logic osc_clk, // Internal oscillator.
	input wire logic osc_rst, // Synchronous reset, active high.
	input wire logic cmd_valid, // One-cycle opcode strobe.
	input wire logic [7:0] cmd_op, // Opcode, stable while strobed.
	input wire logic [15:0] conv_count, // Converter count at period end.
	output logic [15:0] result_r, // Illuminance result.
	output logic result_tgl_r, // Toggles on each result change.
	output logic pwr_on_r, // Powered on.
	output logic meas_active_r // Integration running.
);

	lsc_pkg::lsc_pwr_e st_r;
	logic cont_r;
	logic lres_r;
	logic [7:0] mt_r;
	logic [31:0] cnt_r;
	logic [31:0] target_r;
	logic start;
	logic done;

	// The division is by a constant; a count rounded down to zero is raised to one cycle.
	function automatic logic [31:0] period_cyc(input logic lres, input logic [7:0] mt);
		logic [31:0] base;
		logic [31:0] cyc;
		base = lres ? 32'(L_CYC) : 32'(H_CYC);
		cyc = (base * {24'h00_0000, mt}) / 32'(lsc_pkg::MT_DEFAULT);
		return (cyc == 32'h0000_0000) ? 32'h0000_0001 : cyc;
	endfunction : period_cyc

	assign start = cmd_valid && lsc_pkg::is_meas_op(cmd_op);
	// A command strobe holds the period end off by one cycle; the compare is >= so the
	// period still closes afterwards instead of counting on past its end.
	assign done = (st_r == lsc_pkg::PWR_MEAS_S) && (cnt_r >= target_r - 32'h0000_0001) &&
		!cmd_valid;

	// ==========================================================
	// Power state
	always_ff @(posedge osc_clk) begin
		if (osc_rst) begin
			st_r <= lsc_pkg::PWR_DOWN_S;
		end else if (cmd_valid) begin
			case (cmd_op)
				lsc_pkg::OP_PWR_DOWN: st_r <= lsc_pkg::PWR_DOWN_S;
				lsc_pkg::OP_PWR_ON: st_r <= lsc_pkg::PWR_IDLE_S;
				default: begin
					if (start) begin
						st_r <= lsc_pkg::PWR_MEAS_S;
					end
				end
			endcase
		end else begin
			case (st_r)
				lsc_pkg::PWR_MEAS_S: begin
					if (done && !cont_r) begin
						st_r <= lsc_pkg::PWR_DOWN_S;
					end
				end
				default: st_r <= st_r;
			endcase
		end
	end

	// ==========================================================
	// Mode and period; the period is taken at each start so a later
	// time-value change never stretches an integration already running.
	always_ff @(posedge osc_clk) begin
		if (osc_rst) begin
			cont_r <= 1'b0;
			lres_r <= 1'b0;
			target_r <= 32'h0000_0001;
		end else if (start) begin
			cont_r <= !cmd_op[lsc_pkg::OP_CONT_BIT + 1];
			lres_r <= cmd_op[lsc_pkg::OP_LRES_BIT];
			target_r <= period_cyc(cmd_op[lsc_pkg::OP_LRES_BIT], mt_r);
		end else if (done) begin
			target_r <= period_cyc(lres_r, mt_r);
		end
	end

	always_ff @(posedge osc_clk) begin
		if (osc_rst || start || done || (st_r != lsc_pkg::PWR_MEAS_S)) begin
			cnt_r <= 32'h0000_0000;
		end else begin
			cnt_r <= cnt_r + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Integration time value
	always_ff @(posedge osc_clk) begin
		if (osc_rst) begin
			mt_r <= lsc_pkg::MT_RESET;
		end else if (cmd_valid && cmd_op[7:3] == lsc_pkg::OP_MT_HI_PFX) begin
			mt_r[7:5] <= cmd_op[2:0];
		end else if (cmd_valid && cmd_op[7:5] == lsc_pkg::OP_MT_LO_PFX) begin
			mt_r[4:0] <= cmd_op[4:0];
		end
	end

	// ==========================================================
	// Result register
	always_ff @(posedge osc_clk) begin
		if (osc_rst) begin
			result_r <= lsc_pkg::RESULT_RESET;
			result_tgl_r <= 1'b0;
		end else if (cmd_valid && cmd_op == lsc_pkg::OP_RESULT_CLR &&
			st_r != lsc_pkg::PWR_DOWN_S) begin
			result_r <= lsc_pkg::RESULT_RESET;
			result_tgl_r <= !result_tgl_r;
		end else if (done) begin
			result_r <= conv_count;
			result_tgl_r <= !result_tgl_r;
		end
	end

	always_ff @(posedge osc_clk) begin
		if (osc_rst) begin
			pwr_on_r <= 1'b0;
			meas_active_r <= 1'b0;
		end else begin
			pwr_on_r <= (st_r != lsc_pkg::PWR_DOWN_S);
			meas_active_r <= (st_r == lsc_pkg::PWR_MEAS_S);
		end
	end

	default clocking @(posedge osc_clk); endclocking
	default disable iff (osc_rst);

	a_pwr_down_cmd: assert property (cmd_valid && cmd_op == lsc_pkg::OP_PWR_DOWN
		|=> st_r == lsc_pkg::PWR_DOWN_S ##1 !pwr_on_r) else $error("power down not taken");
	a_pwr_on_cmd: assert property (cmd_valid && cmd_op == lsc_pkg::OP_PWR_ON
		|=> st_r == lsc_pkg::PWR_IDLE_S) else $error("power on not taken");
	a_clr_ignored: assert property (cmd_valid && cmd_op == lsc_pkg::OP_RESULT_CLR &&
		st_r == lsc_pkg::PWR_DOWN_S |=> $stable(result_r)) else $error("clear in power down");
	a_clr_only_result: assert property (cmd_valid && cmd_op == lsc_pkg::OP_RESULT_CLR &&
		st_r != lsc_pkg::PWR_DOWN_S |=> result_r == 16'h0000 && $stable(mt_r) && $stable(st_r))
		else $error("clear wrong");
	a_once_ends: assert property (done && !cont_r |=> st_r == lsc_pkg::PWR_DOWN_S &&
		result_r == $past(conv_count)) else $error("one-shot did not end");
	a_cont_keeps: assert property (done && cont_r |=> st_r == lsc_pkg::PWR_MEAS_S &&
		cnt_r == 32'h0000_0000 && result_r == $past(conv_count)) else $error("continuous stopped");
	a_mt_high: assert property (cmd_valid && cmd_op[7:3] == lsc_pkg::OP_MT_HI_PFX
		|=> mt_r[7:5] == $past(cmd_op[2:0]) && $stable(mt_r[4:0])) else $error("mt high load");
	a_mt_low: assert property (cmd_valid && cmd_op[7:5] == lsc_pkg::OP_MT_LO_PFX
		|=> mt_r[4:0] == $past(cmd_op[4:0]) && $stable(mt_r[7:5])) else $error("mt low load");
	a_restart: assert property (start |=> st_r == lsc_pkg::PWR_MEAS_S && cnt_r == 0 &&
		target_r == period_cyc($past(cmd_op[1]), $past(mt_r))) else $error("restart wrong");

endmodule : lsc_meas_engine

// File: verif/lsc_host_model.sv
// Serial bus master standing in for the host processor on the far side of the sensor.
`timescale 1ns/10ps
module lsc_host_model (
	input wire logic core_clk, // Host timing clock.
	input wire logic sda_out, // Device drive value.
	input wire logic sda_oe, // Device drive enable.
	output logic scl, // Serial clock driven by the host.
	output logic sda_line // Resolved data wire level.
);
	logic pull_r;
	logic ack_r;
	logic lb;
	logic [7:0] rx_r;

	// The wire has a pull-up: released by both sides it reads high.
	assign sda_line = (sda_oe ? sda_out : 1'b1) & ~pull_r;

	initial begin
		scl = 1'b1;
		pull_r = 1'b0;
		ack_r = 1'b0;
		lb = 1'b1;
		rx_r = 8'h00;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wt

	// Each phase lasts four core cycles, above the two that the filters need.
	task automatic bit_io(input logic b);
		pull_r <= ~b;
		wt(4);
		scl <= 1'b1;
		wt(4);
		lb = sda_line;
		wt(4);
		scl <= 1'b0;
		wt(4);
	endtask : bit_io

	task automatic byte_io(input logic [7:0] d, input logic mack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i]);
			rx_r[i] = lb;
		end
		bit_io(~mack);
		ack_r = ~lb;
	endtask : byte_io

	task automatic start_c();
		pull_r <= 1'b1;
		wt(8);
		scl <= 1'b0;
		wt(4);
	endtask : start_c

	task automatic stop_c();
		pull_r <= 1'b1;
		wt(4);
		scl <= 1'b1;
		wt(4);
		pull_r <= 1'b0;
		wt(12);
	endtask : stop_c

	// One opcode per transaction, always closed by a stop.
	task automatic write_op(input logic [6:0] addr, input logic [7:0] op, output logic ok);
		logic a;
		start_c();
		byte_io({addr, 1'b0}, 1'b0);
		a = ack_r;
		byte_io(op, 1'b0);
		ok = a & ack_r;
		stop_c();
	endtask : write_op

	task automatic read_res(input logic [6:0] addr, output logic [15:0] v, output logic ok);
		v = 16'h0000;
		start_c();
		byte_io({addr, 1'b1}, 1'b0);
		ok = ack_r;
		if (ok) begin
			byte_io(8'hFF, 1'b1);
			v[15:8] = rx_r;
			byte_io(8'hFF, 1'b0);
			v[7:0] = rx_r;
		end
		stop_c();
	endtask : read_res

	// Chains two opcodes on purpose so that the refusal of the second byte is seen.
	task automatic write_two(input logic [6:0] addr, input logic [7:0] op_a,
		input logic [7:0] op_b, output logic ok_b);
		start_c();
		byte_io({addr, 1'b0}, 1'b0);
		byte_io(op_a, 1'b0);
		byte_io(op_b, 1'b0);
		ok_b = ack_r;
		stop_c();
	endtask : write_two
endmodule : lsc_host_model

// File: verif/light_sensor_command_control_test.sv
// Self-checking bench of the light sensor control block against a behavioural model.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin miscompares++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module light_sensor_command_control_test;
	localparam int HC = 69;
	localparam int LC = 23;
	logic core_clk = 1'b0;
	logic osc_clk = 1'b0;
	logic srst = 1'b1;
	logic rst_pin_n = 1'b0;
	logic addr_sel = 1'b0;
	logic [15:0] conv_count = 16'h0000;
	logic [15:0] conv_nxt = 16'h0000;
	logic scl, sda_line, sda_out, sda_oe, pwr_on, meas_active, ok, m_on;
	logic [31:0] seed = 32'h0000_94e8;
	logic [7:0] m_mt = 8'h45;
	logic [15:0] m_res = 16'h0000;
	logic [15:0] rd;
	logic [7:0] ops1 [3] = '{8'h20, 8'h21, 8'h23};
	logic [7:0] ops2 [3] = '{8'h10, 8'h11, 8'h13};
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;
	int act_cnt = 0;

	lsc_light_sensor #(.H_CYC(HC), .L_CYC(LC)) i_lsc_light_sensor (.core_clk(core_clk),
		.srst(srst), .osc_clk(osc_clk), .rst_pin_n(rst_pin_n), .scl(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .conv_count(conv_count),
		.pwr_on(pwr_on), .meas_active(meas_active));
	lsc_host_model i_lsc_host_model (.core_clk(core_clk), .sda_out(sda_out), .sda_oe(sda_oe),
		.scl(scl), .sda_line(sda_line));

	always #5 core_clk = ~core_clk;
	initial begin
		#7.3;
		forever #32 osc_clk = ~osc_clk;
	end
	always @(posedge osc_clk) begin
		conv_count <= conv_nxt;
		if (meas_active === 1'b1) act_cnt++;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			give_verdict();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	function automatic int per(input logic [7:0] op);
		int p;
		p = ((op[1] ? LC : HC) * m_mt) / 69;
		return (p < 1) ? 1 : p;
	endfunction : per

	task automatic settle(input int n);
		repeat (n * 7 + 40) @(posedge core_clk);
	endtask : settle

	task automatic new_conv();
		seed = xs(seed);
		@(posedge core_clk);
		conv_nxt <= seed[15:0];
	endtask : new_conv

	task automatic wr(input logic [7:0] op);
		i_lsc_host_model.write_op(addr_sel ? lsc_pkg::ADDR_SEL_HI : lsc_pkg::ADDR_SEL_LO, op, ok);
		`CHK("write ack", 1'b1, ok)
		if (op == 8'h07) begin
			if (m_on) m_res = 16'h0000;
		end else if (op[7:6] == 2'b01) begin
			if (op[5]) m_mt[4:0] = op[4:0];
			else m_mt[7:5] = op[2:0];
		end else m_on = (op == 8'h01) || (op[7:4] == 4'h1);
	endtask : wr

	task automatic rdchk();
		i_lsc_host_model.read_res(addr_sel ? lsc_pkg::ADDR_SEL_HI : lsc_pkg::ADDR_SEL_LO, rd, ok);
		`CHK("read ack", 1'b1, ok)
		`CHK("result", m_res, rd)
	endtask : rdchk

	task automatic oneshot(input logic [7:0] op);
		int p;
		p = per(op);
		new_conv();
		act_cnt = 0;
		wr(op);
		settle(p + 20);
		`CHK("pwr_on after single", 1'b0, pwr_on)
		`CHK("period", 1'b1, (act_cnt >= p - 1) && (act_cnt <= p + 1))
		m_res = conv_nxt;
		rdchk();
	endtask : oneshot

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// Main sequence
	initial begin
		m_on = 1'b0;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		repeat (108) @(posedge core_clk);
		rst_pin_n <= 1'b1;
		settle(6);
		`CHK("pwr_on at reset", 1'b0, pwr_on)
		rdchk();
		for (int a = 0; a < 2; a++) begin
			addr_sel <= a[0];
			repeat (10) @(posedge core_clk);
			i_lsc_host_model.read_res(a[0] ? lsc_pkg::ADDR_SEL_LO : lsc_pkg::ADDR_SEL_HI, rd, ok);
			`CHK("other address ack", 1'b0, ok)
			rdchk();
		end
		$display("test address done");
		foreach (ops1[i]) oneshot(ops1[i]);
		$display("test single done");
		wr(8'h07);
		rdchk();
		wr(8'h01);
		settle(10);
		`CHK("pwr_on idle", 1'b1, pwr_on)
		`CHK("meas_active idle", 1'b0, meas_active)
		wr(8'h07);
		settle(10);
		rdchk();
		$display("test clear done");
		wr(8'h44);
		wr(8'h6A);
		oneshot(8'h20);
		$display("test time value done");
		foreach (ops2[i]) begin
			wr(ops2[i]);
			for (int k = 0; k < 2; k++) begin
				new_conv();
				settle(2 * per(ops2[i]) + 10);
				m_res = conv_nxt;
				`CHK("pwr_on running", 1'b1, pwr_on)
				rdchk();
			end
		end
		wr(8'h00);
		settle(10);
		`CHK("pwr_on down", 1'b0, pwr_on)
		i_lsc_host_model.write_two(addr_sel ? lsc_pkg::ADDR_SEL_HI : lsc_pkg::ADDR_SEL_LO,
			8'h00, 8'h01, ok);
		`CHK("chained ack", 1'b0, ok)
		settle(10);
		`CHK("pwr_on chained", 1'b0, pwr_on)
		$display("test continuous done");
		wr(8'h10);
		settle(20);
		rst_pin_n <= 1'b0;
		repeat (40) @(posedge core_clk);
		`CHK("pwr_on pin reset", 1'b0, pwr_on)
		rst_pin_n <= 1'b1;
		settle(6);
		m_mt = 8'h45;
		m_res = 16'h0000;
		m_on = 1'b0;
		rdchk();
		oneshot(8'h20);
		$display("test reset pin done");
		give_verdict();
	end
endmodule : light_sensor_command_control_test
